// file: logic/supervisor_pkg.sv
// constants and types shared by the supervisor watchdog reset block
package supervisor_pkg;

   // ==========================================================
   // clock and timing
   localparam int unsigned CLK_KHZ          = 10000;
   localparam int unsigned T_RST_HOLD_MS    = 250;
   localparam int unsigned T_NV_WRITE_MS    = 5;
   localparam int unsigned T_WDT0_MS        = 100;
   localparam int unsigned T_WDT1_MS        = 500;
   localparam int unsigned T_WDT2_MS        = 1000;
   localparam int unsigned RST_HOLD_CYC     = T_RST_HOLD_MS * CLK_KHZ;
   localparam int unsigned NV_WRITE_CYC     = T_NV_WRITE_MS * CLK_KHZ;
   localparam int unsigned WDT0_CYC         = T_WDT0_MS * CLK_KHZ;
   localparam int unsigned WDT1_CYC         = T_WDT1_MS * CLK_KHZ;
   localparam int unsigned WDT2_CYC         = T_WDT2_MS * CLK_KHZ;

   typedef logic [23:0] cnt_t;

   // ==========================================================
   // register map
   localparam int unsigned ADDR_W           = 8;
   localparam logic [7:0]  OFS_CONFIG       = 8'h00;
   localparam logic [7:0]  OFS_STATUS       = 8'h04;
   localparam logic [7:0]  OFS_IRQ_STAT     = 8'h08;
   localparam logic [7:0]  OFS_IRQ_MASK     = 8'h0C;
   localparam logic [7:0]  OFS_MEM_ADDR     = 8'h10;
   localparam logic [7:0]  OFS_MEM_DATA     = 8'h14;
   localparam logic [7:0]  OFS_MEM_COMMIT   = 8'h18;

   // config fields (nonvolatile image)
   localparam int unsigned CFG_W            = 6;
   localparam int unsigned CFG_WDT_LSB      = 0;
   localparam int unsigned CFG_PEN_BIT      = 2;
   localparam int unsigned CFG_LOCK_LSB     = 3;
   localparam logic [5:0]  CFG_RESET_VAL    = 6'h00;

   // watchdog interval select
   localparam logic [1:0]  WDT_SEL_0        = 2'h0;
   localparam logic [1:0]  WDT_SEL_1        = 2'h1;
   localparam logic [1:0]  WDT_SEL_2        = 2'h2;
   localparam logic [1:0]  WDT_SEL_OFF      = 2'h3;

   // block lock codes
   localparam logic [2:0]  LOCK_NONE        = 3'h0;
   localparam logic [2:0]  LOCK_1           = 3'h1;
   localparam logic [2:0]  LOCK_2           = 3'h2;
   localparam logic [2:0]  LOCK_4           = 3'h3;
   localparam logic [2:0]  LOCK_8           = 3'h4;
   localparam logic [2:0]  LOCK_ALL         = 3'h5;

   // status bits
   localparam int unsigned ST_RESET_BIT     = 0;
   localparam int unsigned ST_BUSY_BIT      = 1;
   localparam int unsigned ST_WP_BIT        = 2;
   localparam int unsigned ST_UV_BIT        = 3;
   localparam int unsigned ST_SEL0_BIT      = 4;
   localparam int unsigned ST_SEL1_BIT      = 5;

   // interrupt bits
   localparam int unsigned IRQ_W            = 4;
   localparam int unsigned IRQ_WDT_BIT      = 0;
   localparam int unsigned IRQ_UV_BIT       = 1;
   localparam int unsigned IRQ_DONE_BIT     = 2;
   localparam int unsigned IRQ_REFUSE_BIT   = 3;

   // memory geometry
   localparam int unsigned MEM_AW           = 12;
   localparam int unsigned MEM_DEPTH        = 4096;
   localparam int unsigned PAGE_AW          = 6;
   localparam int unsigned PAGE_BYTES       = 64;
   localparam logic [5:0]  PAGE_LAST        = 6'h3F;

endpackage

// file: logic/pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         clk_sys_i,
   input  wire logic         rstn_i,
   // pins and synchronised copy
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   // ==========================================================
   // per bit stages
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta_r;
         logic sync_r;
         always_ff @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
               meta_r <= 1'b0;
               sync_r <= 1'b0;
            end else begin
               meta_r <= d_i[g];
               sync_r <= meta_r;
            end
         end
         assign q_o[g] = sync_r;
      end
   endgenerate

endmodule

// file: logic/supervisor_watchdog_reset.sv
// supervisor: reset output, watchdog, protected config and page memory
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module supervisor_watchdog_reset
   import supervisor_pkg::*;
#(
   parameter int unsigned RST_HOLD_CYCLES = RST_HOLD_CYC,
   parameter int unsigned NV_WRITE_CYCLES = NV_WRITE_CYC,
   parameter int unsigned WDT0_CYCLES     = WDT0_CYC,
   parameter int unsigned WDT1_CYCLES     = WDT1_CYC,
   parameter int unsigned WDT2_CYCLES     = WDT2_CYC,
   parameter bit          ACTIVE_HIGH     = 1'b0
) (
   // clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rstn_i,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [31:0]       reg_wdata_i,
   input  wire logic              reg_we_i,
   input  wire logic              reg_re_i,
   output logic      [31:0]       reg_rdata_o,
   // serial bus pins
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe_o,
   // strap and supply inputs
   input  wire logic              wp_i,
   input  wire logic              select_input_zero_i,
   input  wire logic              select_input_one_i,
   input  wire logic              vcc_low_i,
   // reset pin
   output logic                   reset_pin_o,
   output logic                   reset_pin_oe_o,
   // interrupt
   output logic                   irq_o
);

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      ST_HOLD = 2'b01,
      ST_RUN  = 2'b10
   } sup_state_e;

   typedef enum logic [2:0] {
      NV_IDLE = 3'b001,
      NV_CFG  = 3'b010,
      NV_PAGE = 3'b100
   } nv_state_e;

   typedef struct packed {
      sup_state_e            sup;
      nv_state_e             nv;
      cnt_t                  hold_cnt;
      cnt_t                  wdt_cnt;
      cnt_t                  nv_cnt;
      logic [CFG_W-1:0]      cfg_pend;
      logic [IRQ_W-1:0]      irq_stat;
      logic [IRQ_W-1:0]      irq_mask;
      logic [MEM_AW-1:0]     addr;
      logic [5:0]            nv_page;
      logic [PAGE_BYTES-1:0] pvalid;
      logic                  sda_prev;
      logic [31:0]           rdata;
   } state_s;

   state_s s_r;
   state_s s_nxt;

   // ==========================================================
   // pin synchronisers
   logic [5:0] pins_s;
   logic       scl_s;
   logic       sda_s;
   logic       wp_s;
   logic       sel0_s;
   logic       sel1_s;
   logic       uv_s;

   pin_sync #(
      .W (6)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .d_i       ({vcc_low_i, select_input_one_i, select_input_zero_i, wp_i, sda_i, scl_i}),
      .q_o       (pins_s)
   );

   assign scl_s  = pins_s[0];
   assign sda_s  = pins_s[1];
   assign wp_s   = pins_s[2];
   assign sel0_s = pins_s[3];
   assign sel1_s = pins_s[4];
   assign uv_s   = pins_s[5];

   // ==========================================================
   // memory arrays
   logic [7:0] mem   [MEM_DEPTH];
   logic [7:0] pbuf  [PAGE_BYTES];
   // config image, survives resets like the array
   logic [CFG_W-1:0] nv_cfg_r = CFG_RESET_VAL;

   // ==========================================================
   // decoded helpers
   logic       wr_cfg;
   logic       wr_data;
   logic       wr_commit;
   logic       cfg_locked;
   logic       page_locked;
   logic       restart;
   logic       wdt_en;
   logic       wdt_expire;
   logic       hold_done;
   logic       nv_done;
   cnt_t       wdt_limit;
   logic [6:0] lock_pages;
   logic [6:0] page_ext;
   logic [IRQ_W-1:0] irq_set;

   always_comb begin
      wr_cfg     = reg_we_i && (reg_addr_i == OFS_CONFIG);
      wr_data    = reg_we_i && (reg_addr_i == OFS_MEM_DATA);
      wr_commit  = reg_we_i && (reg_addr_i == OFS_MEM_COMMIT);
      cfg_locked = wp_s && nv_cfg_r[CFG_PEN_BIT];
      // restart edge seen whatever the bus is doing
      restart    = s_r.sda_prev && !sda_s && scl_s;
      wdt_en     = (nv_cfg_r[CFG_WDT_LSB +: 2] != WDT_SEL_OFF);
      unique case (nv_cfg_r[CFG_WDT_LSB +: 2])
         WDT_SEL_0: wdt_limit = cnt_t'(WDT0_CYCLES - 1);
         WDT_SEL_1: wdt_limit = cnt_t'(WDT1_CYCLES - 1);
         WDT_SEL_2: wdt_limit = cnt_t'(WDT2_CYCLES - 1);
         default:   wdt_limit = cnt_t'(WDT2_CYCLES - 1);
      endcase
      wdt_expire = wdt_en && !restart && (s_r.wdt_cnt >= wdt_limit);
      hold_done  = s_r.hold_cnt >= cnt_t'(RST_HOLD_CYCLES - 1);
      nv_done    = (s_r.nv != NV_IDLE) && (s_r.nv_cnt >= cnt_t'(NV_WRITE_CYCLES - 1));
      unique case (nv_cfg_r[CFG_LOCK_LSB +: 3])
         LOCK_1:   lock_pages = 7'h01;
         LOCK_2:   lock_pages = 7'h02;
         LOCK_4:   lock_pages = 7'h04;
         LOCK_8:   lock_pages = 7'h08;
         LOCK_ALL: lock_pages = 7'h40;
         default:  lock_pages = 7'h00;
      endcase
      // locked pages sit at the top of the array
      page_ext    = {1'b0, s_r.addr[MEM_AW-1:PAGE_AW]};
      page_locked = (page_ext + lock_pages) > 7'h3F;
   end

   // ==========================================================
   // next state
   always_comb begin
      s_nxt    = s_r;
      irq_set  = '0;
      s_nxt.sda_prev = sda_s;

      // reset sequencing
      unique case (s_r.sup)
         ST_HOLD: begin
            s_nxt.wdt_cnt = '0;
            if (uv_s) begin
               s_nxt.hold_cnt = '0;
            end else if (hold_done) begin
               s_nxt.sup      = ST_RUN;
               s_nxt.hold_cnt = '0;
            end else begin
               s_nxt.hold_cnt = s_r.hold_cnt + cnt_t'(1);
            end
         end
         ST_RUN: begin
            s_nxt.hold_cnt = '0;
            if (uv_s) begin
               s_nxt.sup = ST_HOLD;
               irq_set[IRQ_UV_BIT] = 1'b1;
            end else if (wdt_expire) begin
               s_nxt.sup = ST_HOLD;
               irq_set[IRQ_WDT_BIT] = 1'b1;
            end
            if (restart || !wdt_en) begin
               s_nxt.wdt_cnt = '0;
            end else begin
               s_nxt.wdt_cnt = s_r.wdt_cnt + cnt_t'(1);
            end
         end
      endcase

      // self-timed nonvolatile writes
      unique case (s_r.nv)
         NV_IDLE: begin
            s_nxt.nv_cnt = '0;
            if (wr_cfg) begin
               if (cfg_locked) begin
                  irq_set[IRQ_REFUSE_BIT] = 1'b1;
               end else begin
                  s_nxt.cfg_pend = reg_wdata_i[CFG_W-1:0];
                  s_nxt.nv       = NV_CFG;
               end
            end else if (wr_commit) begin
               if (page_locked || (s_r.pvalid == '0)) begin
                  irq_set[IRQ_REFUSE_BIT] = 1'b1;
               end else begin
                  s_nxt.nv_page = s_r.addr[MEM_AW-1:PAGE_AW];
                  s_nxt.nv      = NV_PAGE;
               end
            end
         end
         NV_CFG, NV_PAGE: begin
            if (wr_cfg || wr_commit) begin
               irq_set[IRQ_REFUSE_BIT] = 1'b1;
            end
            if (nv_done) begin
               s_nxt.nv     = NV_IDLE;
               s_nxt.nv_cnt = '0;
               irq_set[IRQ_DONE_BIT] = 1'b1;
               if (s_r.nv == NV_PAGE) begin
                  s_nxt.pvalid = '0;
               end
            end else begin
               s_nxt.nv_cnt = s_r.nv_cnt + cnt_t'(1);
            end
         end
         default: begin
            s_nxt.nv = NV_IDLE;
         end
      endcase

      // page buffer load, address wraps inside the page
      if (wr_data && (s_r.nv != NV_PAGE)) begin
         s_nxt.pvalid[s_r.addr[PAGE_AW-1:0]] = 1'b1;
         s_nxt.addr[PAGE_AW-1:0] = s_r.addr[PAGE_AW-1:0] + 6'h01;
      end
      if (reg_we_i && (reg_addr_i == OFS_MEM_ADDR)) begin
         s_nxt.addr = reg_wdata_i[MEM_AW-1:0];
      end
      if (reg_we_i && (reg_addr_i == OFS_IRQ_MASK)) begin
         s_nxt.irq_mask = reg_wdata_i[IRQ_W-1:0];
      end

      // sticky status, a new event wins over the clear
      if (reg_we_i && (reg_addr_i == OFS_IRQ_STAT)) begin
         s_nxt.irq_stat = s_r.irq_stat & ~reg_wdata_i[IRQ_W-1:0];
      end
      s_nxt.irq_stat = s_nxt.irq_stat | irq_set;

      // read data for one cycle only
      s_nxt.rdata = 32'h0000_0000;
      if (reg_re_i) begin
         unique case (reg_addr_i)
            OFS_CONFIG:   s_nxt.rdata = {26'h0, nv_cfg_r};
            OFS_STATUS: begin
               s_nxt.rdata[ST_RESET_BIT] = (s_r.sup == ST_HOLD);
               s_nxt.rdata[ST_BUSY_BIT]  = (s_r.nv != NV_IDLE);
               s_nxt.rdata[ST_WP_BIT]    = wp_s;
               s_nxt.rdata[ST_UV_BIT]    = uv_s;
               s_nxt.rdata[ST_SEL0_BIT]  = sel0_s;
               s_nxt.rdata[ST_SEL1_BIT]  = sel1_s;
            end
            OFS_IRQ_STAT: s_nxt.rdata = {28'h0, s_r.irq_stat};
            OFS_IRQ_MASK: s_nxt.rdata = {28'h0, s_r.irq_mask};
            OFS_MEM_ADDR: s_nxt.rdata = {20'h0, s_r.addr};
            OFS_MEM_DATA: s_nxt.rdata = {24'h0, mem[s_r.addr]};
            default:      s_nxt.rdata = 32'h0000_0000;
         endcase
         if (reg_addr_i == OFS_MEM_DATA) begin
            s_nxt.addr = s_r.addr + 12'h001;
         end
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r.sup      <= ST_HOLD;
         s_r.nv       <= NV_IDLE;
         s_r.hold_cnt <= '0;
         s_r.wdt_cnt  <= '0;
         s_r.nv_cnt   <= '0;
         s_r.cfg_pend <= CFG_RESET_VAL;
         s_r.irq_stat <= '0;
         s_r.irq_mask <= '0;
         s_r.addr     <= '0;
         s_r.nv_page  <= '0;
         s_r.pvalid   <= '0;
         s_r.sda_prev <= 1'b0;
         s_r.rdata    <= 32'h0000_0000;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // memory writes
   always_ff @(posedge clk_sys_i) begin
      if (nv_done && (s_r.nv == NV_CFG)) begin
         nv_cfg_r <= s_r.cfg_pend;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (wr_data && (s_r.nv != NV_PAGE)) begin
         pbuf[s_r.addr[PAGE_AW-1:0]] <= reg_wdata_i[7:0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (nv_done && (s_r.nv == NV_PAGE)) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (s_r.pvalid[i]) begin
               mem[{s_r.nv_page, 6'(i)}] <= pbuf[i];
            end
         end
      end
   end

   // ==========================================================
   // outputs
   logic rst_active;
   assign rst_active     = (s_r.sup == ST_HOLD);
   // open drain: only ever pulls low
   assign reset_pin_o    = 1'b0;
   assign reset_pin_oe_o = ACTIVE_HIGH ? !rst_active : rst_active;
   assign sda_o          = 1'b0;
   assign sda_oe_o       = 1'b0;
   assign reg_rdata_o    = s_r.rdata;
   assign irq_o          = |(s_r.irq_stat & s_r.irq_mask);

endmodule

// file: test/host_kicker.sv
// host model: makes watchdog restart edges on the 2-wire pins
`timescale 1ns/1ps
module host_kicker (
   // control
   input  wire logic run_i,
   // pin levels, pulled up when released
   output logic      scl_o,
   output logic      sda_o
);
   // ==========================================
   // start then stop frame, repeated every 1600 ns
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      forever begin
         wait (run_i);
         #413 sda_o = 1'b0;
         #400 scl_o = 1'b0;
         #400 scl_o = 1'b1;
         #387 sda_o = 1'b1;
      end
   end
endmodule

// file: test/supervisor_watchdog_reset_props.sv
// checker for the supervisor watchdog reset block
`timescale 1ns/1ps
module supervisor_watchdog_reset_props
   import supervisor_pkg::*;
#(
   parameter int unsigned RST_HOLD_CYCLES = 20,
   parameter int unsigned WDT0_CYCLES     = 30,
   parameter bit          ACTIVE_HIGH     = 1'b0
) (
   // clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rstn_i,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [31:0]       reg_wdata_i,
   input  wire logic              reg_we_i,
   input  wire logic              reg_re_i,
   input  wire logic [31:0]       reg_rdata_o,
   // pins
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   input  wire logic              sda_o,
   input  wire logic              sda_oe_o,
   input  wire logic              wp_i,
   input  wire logic              select_input_zero_i,
   input  wire logic              select_input_one_i,
   input  wire logic              vcc_low_i,
   input  wire logic              reset_pin_o,
   input  wire logic              reset_pin_oe_o,
   input  wire logic              irq_o
);
   // ==========================================
   // helper counters
   wire         act = reset_pin_oe_o ^ ACTIVE_HIGH;
   logic        sda_q;
   logic [15:0] good_cnt;
   logic [15:0] idle_cnt;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sda_q    <= 1'b1;
         good_cnt <= 16'h0000;
         idle_cnt <= 16'h0000;
      end else begin
         sda_q    <= sda_i;
         good_cnt <= vcc_low_i ? 16'h0000 : good_cnt + 16'(good_cnt != 16'hFFFF);
         idle_cnt <= (act || (sda_q && !sda_i && scl_i)) ? 16'h0000 : idle_cnt + 16'h0001;
      end
   end
   // ==========================================
   // properties
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   sequence hold_s;
      act [*8];
   endsequence
   por_hold_a: assert property (!$past(rstn_i) |-> hold_s)
      else $error("reset released too early after power-up");
   uv_assert_a: assert property (vcc_low_i |-> ##[1:4] act)
      else $error("undervoltage did not assert reset");
   uv_hold_a: assert property ($fell(vcc_low_i) && act |=> hold_s)
      else $error("reset released right after supply recovery");
   hold_release_a: assert property ($fell(act) |-> 32'(good_cnt) >= RST_HOLD_CYCLES - 1)
      else $error("reset released before good supply hold");
   pins_open_a: assert property (!reset_pin_o && !sda_o && !sda_oe_o)
      else $error("open-drain pin driven high");
   wdt_early_a: assert property ($rose(act) && good_cnt > 16'h0004 |->
      32'(idle_cnt) >= WDT0_CYCLES - 4)
      else $error("watchdog reset despite recent restart edge");
   rdata_idle_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0000_0000)
      else $error("read data outside read cycle");
   irq_reset_a: assert property (!$past(rstn_i) |-> !irq_o)
      else $error("interrupt high after reset");
endmodule
bind supervisor_watchdog_reset supervisor_watchdog_reset_props #(
   .RST_HOLD_CYCLES(RST_HOLD_CYCLES),
   .WDT0_CYCLES(WDT0_CYCLES),
   .ACTIVE_HIGH(ACTIVE_HIGH)
) u_supervisor_watchdog_reset_props (
   .clk_sys_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o,
   .scl_i, .sda_i, .sda_o, .sda_oe_o, .wp_i, .select_input_zero_i, .select_input_one_i,
   .vcc_low_i, .reset_pin_o, .reset_pin_oe_o, .irq_o
);

// file: test/supervisor_watchdog_reset_tb.sv
// self-checking bench for the supervisor watchdog reset block
`timescale 1ns/1ps
module supervisor_watchdog_reset_tb;
   import supervisor_pkg::*;
   localparam int HOLD    = 20;
   localparam int NVW     = 10;
   localparam int LIM [3] = '{30, 50, 80};
   logic              clk_sys_i   = 1'b0;
   logic              rstn_i      = 1'b0;
   logic [ADDR_W-1:0] reg_addr_i  = 8'h00;
   logic [31:0]       reg_wdata_i = 32'h0, reg_rdata_o, rd_v;
   logic              reg_we_i    = 1'b0, reg_re_i = 1'b0, wp_i = 1'b0, vcc_low_i = 1'b0;
   logic              run         = 1'b1, scl_i, sda_h, sda_o, sda_oe_o;
   logic              reset_pin_o, reset_pin_oe_o, irq_o;
   wire logic         sda_i       = sda_h & ~sda_oe_o;
   int                error_cnt   = 0, n_checks = 0, n;
   time               kick_t      = 0;
   initial forever #50 clk_sys_i = ~clk_sys_i;
   always @(negedge sda_i) if (scl_i) kick_t = $time;
   host_kicker u_host_kicker (.run_i(run), .scl_o(scl_i), .sda_o(sda_h));
   supervisor_watchdog_reset #(.RST_HOLD_CYCLES(HOLD), .NV_WRITE_CYCLES(NVW),
      .WDT0_CYCLES(LIM[0]), .WDT1_CYCLES(LIM[1]), .WDT2_CYCLES(LIM[2])
   ) u_supervisor_watchdog_reset (
      .clk_sys_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o,
      .scl_i, .sda_i, .sda_o, .sda_oe_o, .wp_i, .select_input_zero_i(1'b0),
      .select_input_one_i(1'b1), .vcc_low_i, .reset_pin_o, .reset_pin_oe_o, .irq_o);
   // ==========================================
   // helpers
   task automatic chk(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkr(input int v, lo, hi);
      n_checks++;
      if (v < lo || v > hi) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %0d not in %0d..%0d", $time, v, lo, hi);
      end
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge clk_sys_i);
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_we_i    <= 1'b1;
      reg_addr_i  <= ad;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_we_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, output logic [31:0] d);
      @(posedge clk_sys_i);
      reg_re_i   <= 1'b1;
      reg_addr_i <= ad;
      @(posedge clk_sys_i);
      reg_re_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   task automatic rc(input logic [7:0] ad, input logic [31:0] e);
      rd(ad, rd_v);
      chk(rd_v, e);
   endtask
   task automatic wact(input logic v, input int mx);
      n = 0;
      while (reset_pin_oe_o !== v && n < mx) begin
         @(posedge clk_sys_i);
         n++;
      end
   endtask
   task automatic cfg(input logic [5:0] v);
      wr(OFS_CONFIG, {26'h0, v});
      rd(OFS_STATUS, rd_v);
      chk(rd_v[ST_BUSY_BIT], 1'b1);
      wt(NVW);
      rd(OFS_STATUS, rd_v);
      chk(rd_v[ST_BUSY_BIT], 1'b0);
      rc(OFS_CONFIG, {26'h0, v});
      wr(OFS_IRQ_STAT, 32'hF);
   endtask
   task automatic cm(input logic [5:0] pg, input logic [31:0] e);
      wr(OFS_MEM_ADDR, {20'h0, pg, 6'h00});
      wr(OFS_MEM_DATA, 32'hA5);
      wr(OFS_MEM_COMMIT, 32'h0);
      wt(NVW + 2);
      rc(OFS_IRQ_STAT, e);
      wr(OFS_IRQ_STAT, 32'hF);
   endtask
   // ==========================================
   // scenarios
   task automatic t_wdt(input int s);
      cfg(6'(s));
      wt(3 * LIM[s]);
      chk(reset_pin_oe_o, 1'b0);
      run <= 1'b0;
      wact(1'b1, 300);
      chkr(int'(($time - kick_t) / 100), LIM[s], LIM[s] + 8);
      wact(1'b0, HOLD + 10);
      chkr(n, HOLD, HOLD + 5);
      chk(irq_o, 1'b1);
      run <= 1'b1;
      rc(OFS_IRQ_STAT, 32'h1);
      wr(OFS_IRQ_STAT, 32'h1);
      wt(1);
      chk(irq_o, 1'b0);
   endtask
   task automatic t_uv();
      wr(OFS_IRQ_MASK, 32'h0);
      vcc_low_i <= 1'b1;
      wact(1'b1, 8);
      chkr(n, 1, 5);
      wt(30);
      vcc_low_i <= 1'b0;
      wact(1'b0, HOLD + 10);
      chkr(n, HOLD, HOLD + 5);
      rc(OFS_IRQ_STAT, 32'h2);
      chk(irq_o, 1'b0);
      wr(OFS_IRQ_MASK, 32'h2);
      wt(1);
      chk(irq_o, 1'b1);
      wr(OFS_IRQ_STAT, 32'h2);
      wt(1);
      chk(irq_o, 1'b0);
   endtask
   task automatic t_wp();
      cfg(6'h07);
      wp_i <= 1'b1;
      wt(3);
      wr(OFS_CONFIG, 32'h3);
      wt(NVW + 2);
      rc(OFS_CONFIG, 32'h7);
      rc(OFS_IRQ_STAT, 32'h8);
      wp_i <= 1'b0;
      wt(3);
      cfg(6'h03);
      rc(8'h3C, 32'h0);
      rc(OFS_STATUS, 32'h20);
   endtask
   task automatic t_mem();
      for (int i = 1; i < 5; i++) begin
         cfg({3'(i), 3'h3});
         cm(6'(64 - (1 << (i - 1))), 32'h8);
         cm(6'(63 - (1 << (i - 1))), 32'h4);
      end
      cfg({LOCK_ALL, 3'h3});
      cm(6'h00, 32'h8);
      cfg(6'h03);
      cm(6'h3F, 32'h4);
      wr(OFS_MEM_ADDR, 32'h40);
      for (int k = 0; k < 65; k++) wr(OFS_MEM_DATA, 32'(k + 1));
      wr(OFS_MEM_COMMIT, 32'h0);
      wt(NVW + 2);
      wr(OFS_MEM_ADDR, 32'h40);
      for (int k = 0; k < 64; k++) rc(OFS_MEM_DATA, k == 0 ? 32'h41 : 32'(k + 1));
   endtask
   task automatic t_rst();
      wt(1);
      rstn_i <= 1'b0;
      wt(2);
      rstn_i <= 1'b1;
      wact(1'b0, HOLD + 10);
      chkr(n, HOLD, HOLD + 5);
      rc(OFS_CONFIG, 32'h3);
      rc(OFS_IRQ_STAT, 32'h0);
      wr(OFS_MEM_ADDR, 32'h40);
      rc(OFS_MEM_DATA, 32'h41);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ==========================================
   // main sequence and watchdog
   initial begin
      wt(2);
      rstn_i <= 1'b1;
      chk(reset_pin_oe_o, 1'b1);
      wact(1'b0, HOLD + 10);
      chkr(n, HOLD, HOLD + 5);
      wr(OFS_IRQ_MASK, 32'h1);
      for (int s = 0; s < 3; s++) t_wdt(s);
      cfg(6'h03);
      run <= 1'b0;
      wact(1'b1, 200);
      chkr(n, 200, 200);
      run <= 1'b1;
      t_uv();
      t_wp();
      t_mem();
      t_rst();
      results();
   end
   initial begin
      #1000000;
      error_cnt++;
      results();
   end
endmodule
